// ---- core/usw_core.sv ----
// Serial shift/count core with wire-mode pin control and clock selection
`timescale 1ns/1ns
`include "usw_map.svh"
//
// Function
// - Mode zero disables outputs, holds, start detector
// - Inputs keep working in every wire mode
// - Three-wire: data out replaces port bit
// - Two-wire SDA open-drain, low on zero
// - SCL held low after start until cleared
// - Two-wire modes disable SDA/SCL pull-ups
// - Mode three holds SCL on overflow
// - External clock latches output on opposite edge
// - Source zero needs strobe; timer mode uses match
// - External edges clock shifter; counter both edges
// - Strobe shifts and counts once immediately
// - Strobe and toggle bits read zero
// - Toggle inverts clock port bit always
// - External plus strobe bit: toggle clocks counter
// - Shift left, MSB drives data output
// - Overflow flag set on wrap, cleared by one
module usw_core (
  input  wire logic              clock_i,          // System clock
  input  wire logic              resetn_i,         // Async reset, active low
  input  wire logic              clk_en_i,         // Freezes all system-clock state when low; link-side samples keep running
  input  wire logic              link_clk_i,       // Link-side sampling clock
  input  wire usw_pkg::usw_mode_t wire_mode_select_i,   // Wire mode
  input  wire usw_pkg::usw_src_t  clock_source_select_i, // Clock source
  input  wire logic              clock_strobe_bit_i,   // Strobe bit written one
  input  wire logic              clock_strobe_level_i, // Stored strobe bit as selector
  input  wire logic              clock_toggle_bit_i,   // Toggle bit written one
  input  wire logic              timer_match_i,        // Timer compare-match pulse
  input  wire logic              data_wr_i,            // Shift register write
  input  wire usw_pkg::usw_byte_t data_wdata_i,        // Shift register write data
  input  wire logic              start_clear_i,        // Write one to start flag
  input  wire logic              ovf_clear_i,          // Write one to overflow flag
  input  wire logic              do_port_bit_i,        // Port bit of data-out pin
  input  wire logic              do_dir_bit_i,         // Direction of data-out pin
  input  wire logic              sda_port_bit_i,       // Port bit of data-in/SDA pin
  input  wire logic              sda_dir_bit_i,        // Direction of data-in/SDA pin
  input  wire logic              scl_port_bit_i,       // Port bit from port logic
  input  wire logic              clock_pin_direction_bit_i, // Direction of clock pin
  input  wire logic              serial_data_in_pin_i, // SDA/DI pin level
  input  wire logic              serial_clock_pin_i,   // SCL/SERIAL_CLOCK_PIN pin level
  output logic                   do_pin_o,         // Data-out pin level
  output logic                   do_pin_oe_n_o,    // Data-out enable, low drives
  output logic                   do_pullup_o,      // Data-out pull-up enable
  output logic                   sda_pin_o,        // SDA pin level
  output logic                   sda_pin_oe_n_o,   // SDA enable, low drives
  output logic                   sda_pullup_o,     // SDA pull-up enable
  output logic                   scl_pin_o,        // SCL pin level
  output logic                   scl_pin_oe_n_o,   // SCL enable, low drives
  output logic                   scl_pullup_o,     // SCL pull-up enable
  output logic                   scl_port_value_o, // Clock port bit after toggles
  output usw_pkg::usw_byte_t     shift_data_o,     // Shift register contents
  output usw_pkg::usw_count_t    counter_value_o,  // Counter value
  output logic                   start_condition_flag_o, // Start seen
  output logic                   counter_overflow_flag_o, // Counter wrapped
  output logic                   strobe_read_o     // Strobe bits read back
);

  // Link-domain capture of the pins
  logic lk_sda;            // Link-side SDA sample
  logic lk_scl;            // Link-side SCL sample
  // Crossing into the system domain
  logic sda_s1, sda_s2;    // SDA synchroniser stages
  logic scl_s1, scl_s2;    // SCL synchroniser stages
  logic scl_d;             // SCL previous value, edge detect
  logic sda_d;             // SDA previous value, edge detect
  // Core state and next values
  usw_pkg::usw_byte_t  sreg, next_sreg;     // Shift register
  usw_pkg::usw_count_t cnt, next_cnt;       // Four-bit counter
  logic out_latch, next_out_latch;          // Data output latch
  logic di_sample, next_di_sample;          // Data sampled a cycle earlier
  logic start_f, next_start_f;              // Start condition flag
  logic ovf_f, next_ovf_f;                  // Counter overflow flag
  logic scl_port, next_scl_port;            // Clock port bit with toggles
  // Pin outputs and next values
  logic do_q, next_do_q, do_oe_q, next_do_oe_q, do_pu_q, next_do_pu_q;
  logic sda_q, next_sda_q, sda_oe_q, next_sda_oe_q, sda_pu_q, next_sda_pu_q;
  logic scl_q, next_scl_q, scl_oe_q, next_scl_oe_q, scl_pu_q, next_scl_pu_q;
  // Decoded strobes
  logic scl_rise, scl_fall, start_seen, shift_clk, count_clk;
  logic two_wire, ext_src;

  // Pins sampled by the link clock first
  // Not a synchroniser alone; crossing follows below
  // Only the first system stage reads these samples
  // Reset parks them high, the idle level of the lines
  // Avoids a false edge or start right after reset
  // Link clock samples the pins; only a plain register here
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lk_sda <= 1'b1;
      lk_scl <= 1'b1;
    end else begin
      lk_sda <= serial_data_in_pin_i;
      lk_scl <= serial_clock_pin_i;
    end
  end

  // Edge decode sits two stages behind the link sample
  // External edges arrive about three cycles plus one link period late
  // Limitation: external clock must stay well below the system clock
  // Latency traded for a clean crossing
  // Two-flop crossing; first stage read only by second
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else if (clk_en_i) begin
      sda_s1 <= lk_sda;
      sda_s2 <= sda_s1;
      scl_s1 <= lk_scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_d  <= sda_s2;
    end
  end

  // Shift and count strobes are one-cycle enables
  // No derived clock, so all core state stays on clock_i
  // Clock selection and edge decode
  always_comb begin
    two_wire   = wire_mode_select_i[1];
    ext_src    = clock_source_select_i[1];
    scl_rise   = scl_s2 & ~scl_d;
    scl_fall   = ~scl_s2 & scl_d;
    // SDA falling while SCL high marks a start; off in mode zero
    start_seen = two_wire & scl_s2 & scl_d & sda_d & ~sda_s2;
    case (clock_source_select_i)
      `USW_CS_SOFT: begin
        shift_clk = clock_strobe_bit_i;
        count_clk = clock_strobe_bit_i;
      end
      `USW_CS_TIMER: begin
        shift_clk = timer_match_i;
        count_clk = timer_match_i;
      end
      `USW_CS_EXT_POS: begin
        shift_clk = scl_rise;
        count_clk = clock_strobe_level_i ? clock_toggle_bit_i
                                         : (scl_rise | scl_fall);
      end
      `USW_CS_EXT_NEG: begin
        shift_clk = scl_fall;
        count_clk = clock_strobe_level_i ? clock_toggle_bit_i
                                         : (scl_rise | scl_fall);
      end
      default: begin
        shift_clk = 1'b0;
        count_clk = 1'b0;
      end
    endcase
  end

  // Counter wraps freely; flag records each wrap
  // Flag cleared only by its own write-one strobe
  // A data load replaces the shift but not the count
  // Shift register, counter, latch and flags
  always_comb begin
    next_di_sample = sda_s2;
    next_sreg      = sreg;
    next_cnt       = cnt;
    next_ovf_f     = ovf_f;
    next_start_f   = start_f;
    next_scl_port  = scl_port;
    next_out_latch = out_latch;
    // A write wins over a same-cycle shift
    if (data_wr_i) begin
      next_sreg = data_wdata_i;
    end else if (shift_clk) begin
      next_sreg = {sreg[6:0], di_sample};
    end
    if (count_clk) begin
      next_cnt = cnt + 4'h1;
    end
    // Set wins over a clear in the same cycle
    if (count_clk && cnt == `USW_CNT_MAX) begin
      next_ovf_f = 1'b1;
    end else if (ovf_clear_i) begin
      next_ovf_f = 1'b0;
    end
    if (start_seen) begin
      next_start_f = 1'b1;
    end else if (start_clear_i) begin
      next_start_f = 1'b0;
    end
    // Toggle ignores the direction bit
    if (clock_toggle_bit_i) begin
      next_scl_port = ~scl_port;
    end else begin
      next_scl_port = scl_port_bit_i;
    end
    // Internal sources: transparent; external: update on the non-sampling edge
    if (!ext_src) begin
      next_out_latch = next_sreg[7];
    end else if (clock_source_select_i[0] ? scl_rise : scl_fall) begin
      next_out_latch = next_sreg[7];
    end
  end

  // Pins registered, so they follow a strobe at its own edge
  // Enables active low: zero lets the pad drive
  // Two-wire pads only drive zero, pull-ups off
  // Bus then relies on its external resistors
  // Pin drivers per wire mode
  always_comb begin
    next_do_q     = do_port_bit_i;
    next_do_oe_q  = ~do_dir_bit_i;
    next_do_pu_q  = ~do_dir_bit_i & do_port_bit_i;
    next_sda_q    = sda_port_bit_i;
    next_sda_oe_q = ~sda_dir_bit_i;
    next_sda_pu_q = ~sda_dir_bit_i & sda_port_bit_i;
    next_scl_q    = next_scl_port;
    next_scl_oe_q = ~clock_pin_direction_bit_i;
    next_scl_pu_q = ~clock_pin_direction_bit_i & next_scl_port;
    case (wire_mode_select_i)
      `USW_WM_OFF: begin
        next_do_q = do_port_bit_i;
      end
      `USW_WM_THREE: begin
        next_do_q = next_out_latch;
      end
      `USW_WM_TWO, `USW_WM_TWO_HOLD: begin
        // Open drain: only drive low
        next_sda_q    = 1'b0;
        next_sda_oe_q = ~(sda_dir_bit_i & (~next_out_latch | ~sda_port_bit_i));
        next_sda_pu_q = 1'b0;
        next_scl_q    = 1'b0;
        next_scl_oe_q = ~(clock_pin_direction_bit_i & (~next_scl_port | next_start_f
                        | (wire_mode_select_i[0] & next_ovf_f)));
        next_scl_pu_q = 1'b0;
      end
      default: begin
        next_do_q = do_port_bit_i;
      end
    endcase
  end

  // Flags freeze too while clk_en_i is low
  // A stalled enable cannot lose a pending flag
  // Registered state and outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sreg      <= `USW_SR_RESET;
      cnt       <= `USW_CNT_RESET;
      out_latch <= 1'b0;
      di_sample <= 1'b1;
      start_f   <= 1'b0;
      ovf_f     <= 1'b0;
      scl_port  <= 1'b0;
      do_q      <= 1'b0;
      do_oe_q   <= 1'b1;
      do_pu_q   <= 1'b0;
      sda_q     <= 1'b0;
      sda_oe_q  <= 1'b1;
      sda_pu_q  <= 1'b0;
      scl_q     <= 1'b0;
      scl_oe_q  <= 1'b1;
      scl_pu_q  <= 1'b0;
    end else if (clk_en_i) begin
      sreg      <= next_sreg;
      cnt       <= next_cnt;
      out_latch <= next_out_latch;
      di_sample <= next_di_sample;
      start_f   <= next_start_f;
      ovf_f     <= next_ovf_f;
      scl_port  <= next_scl_port;
      do_q      <= next_do_q;
      do_oe_q   <= next_do_oe_q;
      do_pu_q   <= next_do_pu_q;
      sda_q     <= next_sda_q;
      sda_oe_q  <= next_sda_oe_q;
      sda_pu_q  <= next_sda_pu_q;
      scl_q     <= next_scl_q;
      scl_oe_q  <= next_scl_oe_q;
      scl_pu_q  <= next_scl_pu_q;
    end
  end

  // Outputs straight from flops; strobe read-back tied to zero
  assign do_pin_o                = do_q;
  assign do_pin_oe_n_o           = do_oe_q;
  assign do_pullup_o             = do_pu_q;
  assign sda_pin_o               = sda_q;
  assign sda_pin_oe_n_o          = sda_oe_q;
  assign sda_pullup_o            = sda_pu_q;
  assign scl_pin_o               = scl_q;
  assign scl_pin_oe_n_o          = scl_oe_q;
  assign scl_pullup_o            = scl_pu_q;
  assign scl_port_value_o        = scl_port;
  assign shift_data_o            = sreg;
  assign counter_value_o         = cnt;
  assign start_condition_flag_o  = start_f;
  assign counter_overflow_flag_o = ovf_f;
  assign strobe_read_o           = 1'b0;

endmodule : usw_core

// ---- inc/usw_map.svh ----
// Constant map for the wire-mode and clock-select serial block
`ifndef USW_MAP_SVH
`define USW_MAP_SVH
`define USW_WM_OFF      2'h0
`define USW_WM_THREE    2'h1
`define USW_WM_TWO      2'h2
`define USW_WM_TWO_HOLD 2'h3
`define USW_CS_SOFT     2'h0
`define USW_CS_TIMER    2'h1
`define USW_CS_EXT_POS  2'h2
`define USW_CS_EXT_NEG  2'h3
`define USW_SR_RESET    8'h00
`define USW_CNT_RESET   4'h0
`define USW_CNT_MAX     4'hf
`endif

// ---- inc/usw_pkg.sv ----
// Types for the wire-mode and clock-select serial block
package usw_pkg;
  typedef logic [1:0] usw_mode_t;   // Wire mode field
  typedef logic [1:0] usw_src_t;    // Clock source field
  typedef logic [7:0] usw_byte_t;   // Shift register word
  typedef logic [3:0] usw_count_t;  // Counter value
endpackage : usw_pkg

// ---- testbench/usw_core_chk.sv ----
// Port-level assertions for the serial shift and count core
`timescale 1ns/1ns
module usw_core_chk (
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       clk_en_i,
  input wire logic [1:0] wire_mode_select_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic       clock_strobe_bit_i,
  input wire logic       clock_toggle_bit_i,
  input wire logic       data_wr_i,
  input wire logic       ovf_clear_i,
  input wire logic       clock_pin_direction_bit_i,
  input wire logic       scl_pin_oe_n_o,
  input wire logic       scl_port_value_o,
  input wire logic [7:0] shift_data_o,
  input wire logic [3:0] counter_value_o,
  input wire logic       start_condition_flag_o,
  input wire logic       counter_overflow_flag_o,
  input wire logic       strobe_read_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // One software strobe step that no write overrides
  sequence soft_step;
    clk_en_i && clock_source_select_i == 2'h0 && clock_strobe_bit_i && !data_wr_i;
  endsequence
  // Overflow hold armed for two samples, covers the registered pin lag
  sequence hold_armed;
    (wire_mode_select_i == 2'h3 && clock_pin_direction_bit_i && counter_overflow_flag_o) [*2];
  endsequence
  AST_STROBE_ZERO: assert property (!strobe_read_o)
    else $error("strobe bits read back as one");
  AST_SOFT_COUNT: assert property (soft_step |=> counter_value_o == $past(counter_value_o) + 4'h1)
    else $error("strobe did not count once");
  AST_NO_CLOCK: assert property (clock_source_select_i == 2'h0 && !clock_strobe_bit_i
    && !clock_toggle_bit_i |=> $stable(counter_value_o)) else $error("counter moved unclocked");
  AST_SHIFT_LEFT: assert property (soft_step |=> shift_data_o[7:1] == $past(shift_data_o[6:0]))
    else $error("shift not one step left");
  AST_OVF_SET: assert property (soft_step and counter_value_o == 4'hf |=>
    counter_overflow_flag_o && counter_value_o == 4'h0) else $error("wrap did not set flag");
  AST_OVF_KEEP: assert property (counter_overflow_flag_o && !ovf_clear_i |=> counter_overflow_flag_o)
    else $error("overflow flag lost");
  AST_TOGGLE: assert property (clk_en_i && clock_toggle_bit_i |=> scl_port_value_o != $past(scl_port_value_o))
    else $error("toggle did not invert");
  AST_OVF_HOLD: assert property (hold_armed |-> !scl_pin_oe_n_o)
    else $error("clock line not held");
  AST_START_OFF: assert property ((wire_mode_select_i == 2'h0) [*4] |-> !$rose(start_condition_flag_o))
    else $error("start flag in mode zero");
  // Start hold armed for two samples in a two-wire mode
  sequence start_hold;
    (wire_mode_select_i[1] && clock_pin_direction_bit_i && start_condition_flag_o) [*2];
  endsequence
  AST_START_HOLD: assert property (start_hold |-> !scl_pin_oe_n_o)
    else $error("clock line not held after start");
endmodule : usw_core_chk
bind usw_core usw_core_chk chk (.*);

// ---- testbench/usw_peer.sv ----
// Far-side serial peer driving the open-drain clock and data lines
`timescale 1ns/1ns
module usw_peer (
  input  wire logic link_clk_i, // Paces the peer
  output logic      scl_o,      // Clock drive, one means released
  output logic      sda_o       // Data drive, one means released
);
  // Released lines sit high on their pull-ups; clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Data falls while clock high, then one clock pulse
  task automatic start_cond;
    @(posedge link_clk_i) sda_o <= 1'b0;
    @(posedge link_clk_i) scl_o <= 1'b0;
    @(posedge link_clk_i) scl_o <= 1'b1;
  endtask : start_cond
  // Data set while clock low, most significant bit first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge link_clk_i) scl_o <= 1'b0;
      @(posedge link_clk_i) sda_o <= b[i];
      @(posedge link_clk_i) scl_o <= 1'b1;
    end
    @(posedge link_clk_i) sda_o <= 1'b1;
  endtask : send_byte
  // Let go of both lines at the next link edge
  task automatic release_lines;
    @(posedge link_clk_i) begin
      sda_o <= 1'b1;
      scl_o <= 1'b1;
    end
  endtask : release_lines
endmodule : usw_peer

// ---- testbench/usw_core_tb.sv ----
// Self-checking bench for the wire-mode and clock-select core
`timescale 1ns/1ns
module usw_core_tb;
  logic clock_i, resetn_i, clk_en_i, link_clk_i, clock_strobe_bit_i, clock_strobe_level_i;
  logic clock_toggle_bit_i, timer_match_i, data_wr_i, start_clear_i, ovf_clear_i, peer_sda;
  logic do_port_bit_i, do_dir_bit_i, sda_port_bit_i, sda_dir_bit_i, scl_port_bit_i, peer_scl;
  logic clock_pin_direction_bit_i, serial_data_in_pin_i, serial_clock_pin_i, do_pullup_o;
  logic do_pin_o, do_pin_oe_n_o, sda_pin_o, sda_pin_oe_n_o, sda_pullup_o, scl_pin_o;
  logic scl_pin_oe_n_o, scl_pullup_o, scl_port_value_o, start_condition_flag_o;
  logic counter_overflow_flag_o, strobe_read_o;
  usw_pkg::usw_mode_t  wire_mode_select_i;
  usw_pkg::usw_src_t   clock_source_select_i;
  usw_pkg::usw_byte_t  data_wdata_i, shift_data_o;
  usw_pkg::usw_count_t counter_value_o;
  int err_count = 0;
  int check_count = 0;
  // Open-drain lines: either party may only pull low
  assign serial_data_in_pin_i = peer_sda & (sda_pin_oe_n_o | sda_pin_o);
  assign serial_clock_pin_i = peer_scl & (scl_pin_oe_n_o | scl_pin_o);
  usw_core dut (.*);
  usw_peer peer (.link_clk_i, .scl_o(peer_scl), .sda_o(peer_sda));
  // System clock, 8 ns
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // Link clock, 48 ns, phase offset from the system clock
  initial begin
    link_clk_i = 1'b0;
    #3;
    forever #24 link_clk_i = ~link_clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Back-to-back one-cycle pulses, launched on falling edges
  task automatic pls(ref logic s, input int n);
    repeat (n) @(negedge clock_i) s = 1'b1;
    @(negedge clock_i) s = 1'b0;
  endtask : pls
  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wt
  // Three-wire strobe shifting, counting and wrap
  task automatic t_soft;
    chk({counter_value_o, strobe_read_o, counter_overflow_flag_o}, 6'h00);
    wire_mode_select_i = 2'h1;
    do_dir_bit_i = 1'b1;
    data_wdata_i = 8'ha5;
    pls(data_wr_i, 1);
    pls(clock_strobe_bit_i, 2);
    chk(shift_data_o, 8'h97);
    chk({do_pin_o, do_pin_oe_n_o, counter_value_o}, 6'h22);
    pls(clock_strobe_bit_i, 14);
    chk({counter_value_o, counter_overflow_flag_o}, 5'h01);
    pls(ovf_clear_i, 1);
    chk(counter_overflow_flag_o, 1'b0);
  endtask : t_soft
  // Overflow hold of the clock line in mode three
  task automatic t_hold;
    wire_mode_select_i = 2'h3;
    {clock_pin_direction_bit_i, scl_port_bit_i} = 2'h3;
    pls(clock_strobe_bit_i, 16);
    wt(2);
    chk(scl_pin_oe_n_o, 1'b0);
    pls(ovf_clear_i, 1);
    wt(2);
    chk(scl_pin_oe_n_o, 1'b1);
  endtask : t_hold
  // Timer match clocks, strobe ignored
  task automatic t_timer;
    clock_source_select_i = 2'h1;
    pls(timer_match_i, 2);
    pls(clock_strobe_bit_i, 1);
    chk(counter_value_o, 4'h2);
  endtask : t_timer
  // Start condition hold, release, open-drain data drive
  task automatic t_start;
    wire_mode_select_i = 2'h2;
    clock_source_select_i = 2'h0;
    peer.start_cond;
    wt(8);
    chk({start_condition_flag_o, scl_pin_oe_n_o, serial_clock_pin_i}, 3'h4);
    pls(start_clear_i, 1);
    wt(8);
    chk({start_condition_flag_o, scl_pin_oe_n_o}, 2'h1);
    scl_port_bit_i = 1'b0;
    sda_dir_bit_i = 1'b1;
    wt(2);
    chk({sda_pin_oe_n_o, sda_pin_o, sda_pullup_o, scl_pullup_o, scl_pin_o}, 5'h00);
    // Lines float high before external clocking, so no stray edge counts
    {sda_dir_bit_i, clock_pin_direction_bit_i} = 2'h0;
    peer.release_lines;
    wt(16);
  endtask : t_start
  // External clocking with outputs off
  task automatic t_ext;
    wire_mode_select_i = 2'h0;
    clock_source_select_i = 2'h2;
    clock_pin_direction_bit_i = 1'b0;
    peer.send_byte(8'h5c);
    peer.start_cond;
    wt(12);
    chk(shift_data_o, 8'hb8);
    chk({counter_value_o, counter_overflow_flag_o, start_condition_flag_o}, 6'h12);
    {do_dir_bit_i, do_port_bit_i} = 2'h1;
    wt(2);
    chk({do_pin_o, do_pin_oe_n_o, do_pullup_o}, 3'h7);
  endtask : t_ext
  // Toggle strobe inverts the port bit and clocks the counter
  task automatic t_toggle;
    clock_strobe_level_i = 1'b1;
    pls(clock_toggle_bit_i, 1);
    chk(scl_port_value_o, 1'b1);
    pls(clock_toggle_bit_i, 2);
    chk(counter_value_o, 4'h7);
  endtask : t_toggle
  task automatic end_sim;
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    {clock_strobe_bit_i, clock_strobe_level_i, clock_toggle_bit_i, timer_match_i} = 4'h0;
    {data_wr_i, start_clear_i, ovf_clear_i, do_port_bit_i, do_dir_bit_i} = 5'h00;
    {sda_port_bit_i, sda_dir_bit_i, scl_port_bit_i, clock_pin_direction_bit_i} = 4'h0;
    {wire_mode_select_i, clock_source_select_i, data_wdata_i} = 12'h000;
    clk_en_i = 1'b1;
    resetn_i = 1'b0;
    wt(6);
    resetn_i = 1'b1;
    t_soft;
    t_hold;
    t_timer;
    t_start;
    t_ext;
    t_toggle;
    end_sim;
  end
  // Watchdog well beyond the expected run
  initial begin
    #50000;
    err_count++;
    end_sim;
  end
endmodule : usw_core_tb
